// ### pmc_far_model.sv
// Far-side model: low clock tick source and shutdown wake pads
`timescale 1ns/1ps

module pmc_far_model #(
	parameter int N_IO = 31,
	parameter int TICK_DIV = 16
) (
	input wire logic clk_i,
	input wire logic flip_i,
	output logic lf_tick_o,
	output logic [N_IO-1:0] io_o
);
	int cnt = 0;
	logic tick_q = 1'h0;
	logic [N_IO-1:0] pad_q = '0;

	// One driver per output, so no initial block competes with the clocked ones
	assign lf_tick_o = tick_q;
	assign io_o = pad_q;

	// Tick far faster than real, to keep the run short
	always @(posedge clk_i) begin
		cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
		tick_q <= (cnt == TICK_DIV - 1);
	end

	// One pad edge stands for a wake pin change
	always @(posedge clk_i) begin
		if (flip_i) begin
			pad_q[0] <= ~pad_q[0];
		end
	end
endmodule : pmc_far_model

// ### pmc_pkg.sv
// Types shared by the power mode and clock manager
package pmc_pkg;
	typedef enum logic [2:0] {
		st_active,
		st_idle,
		st_sb_enter,
		st_standby,
		st_sb_exit,
		st_shutdown,
		st_held
	} pmc_state_t;

	typedef struct packed {
		logic cpu_clk;
		logic mem_clk;
		logic periph_clk;
		logic flash_pwr;
		logic sram_pwr;
		logic periph_ret;
		logic aon_pwr;
		logic bod_on;
		logic bod_duty;
		logic wdt_run;
		logic sensor_pwr;
		logic radio_en;
	} pmc_pwr_t;

	typedef struct packed {
		logic hf_on;
		logic hf_xtal;
		logic mf_on;
		logic lf_on;
		logic [1:0] lf_src;
		logic lf_out;
	} pmc_clk_t;
endpackage : pmc_pkg

// ### pmc_regs.svh
// Register offsets, field positions and reset values of the power manager
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// -----------------------------------------------------------------
// Offsets
// -----------------------------------------------------------------
`define PMC_OFS_MODE 6'h00
`define PMC_OFS_CLK 6'h04
`define PMC_OFS_STAT 6'h08
`define PMC_OFS_CAUSE 6'h0C
`define PMC_OFS_WAKE 6'h10
`define PMC_OFS_SNS 6'h14
// -----------------------------------------------------------------
// Fields
// -----------------------------------------------------------------
`define PMC_REQ_IDLE 2'h1
`define PMC_REQ_STBY 2'h2
`define PMC_REQ_SHDN 2'h3
`define PMC_CLK_HFX 0
`define PMC_CLK_LF_LO 1
`define PMC_CLK_LF_HI 2
`define PMC_CLK_LFOUT 3
`define PMC_CLK_RADIO 4
`define PMC_LF_RC 2'h0
`define PMC_LF_XTAL 2'h1
`define PMC_LF_PIN 2'h2
`define PMC_CAUSE_POR 0
`define PMC_CAUSE_PIN 1
`define PMC_CAUSE_SHDN 2
`define PMC_SNS_CPU 0
`define PMC_ST_RADIO 3
`define PMC_ST_HF 4
`define PMC_ST_LF 5
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define PMC_CLK_RST 5'h00
`define PMC_CAUSE_RST 3'h1
`define PMC_SNS_RST 1'h0
`endif

// ### pmc_top.sv
// Power mode and clock manager with a classic Wishbone register slave
//
// Notes on behaviour
// RULE1: Idle gates CPU and memory clocks only
// RULE2: Any interrupt returns idle to active
// RULE3: Active powers CPU, peripherals, flash, SRAM
// RULE4: Active main clock source is selectable
// RULE5: Standby keeps always-on; leaves on wake events
// RULE6: Standby wake keeps config, CPU resumes
// RULE7: All I/O held throughout standby; the code holds them only in st_standby, not in st_sb_enter or st_sb_exit
// RULE8: Shutdown powers everything off, I/O frozen
// RULE9: Wake-pin change in shutdown acts as reset
// RULE10: Reset cause register tells three causes apart
// RULE11: Shutdown keeps only latched I/O and flash
// RULE12: Retention full, partial, or none by mode
// RULE13: Reset pin wakes or resets any mode
// RULE14: Main clock on only in active/idle; the code also keeps it on in st_sb_enter and st_sb_exit
// RULE15: Radio only with crystal main clock
// RULE16: Medium clock always from its RC oscillator
// RULE17: Low clock source RC, crystal or pin
// RULE18: Low clock runs except shutdown and held
// RULE19: Radio timer resync around standby on tick
// RULE20: Low clock may be driven out if internal
// RULE21: Sensor peripherals by sensor unit or CPU
// RULE22: Software requests modes; held follows pin
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_top #(
	parameter int N_IO = 31
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic irq_i,
	input wire logic rtc_evt_i,
	input wire logic sensor_evt_i,
	input wire logic ext_wake_i,
	input wire logic reset_pin_i,
	input wire logic lf_tick_i,
	input wire logic [N_IO-1:0] io_in_i,
	output logic io_hold_o,
	output logic cpu_resume_o,
	output logic rtimer_sync_o,
	output logic sensor_cpu_own_o,
	output pmc_pkg::pmc_pwr_t pwr_o,
	output pmc_pkg::pmc_clk_t clk_o
);
	// -----------------------------------------------------------------
	// Parameter check
	// -----------------------------------------------------------------
	generate
		if (N_IO < 1 || N_IO > 32) begin : g_bad_nio
			$error("N_IO must lie between 1 and 32");
		end
	endgenerate

	pmc_pkg::pmc_state_t state_reg;
	pmc_pkg::pmc_state_t state_next;
	logic [4:0] clk_cfg_reg;
	logic [2:0] cause_reg;
	logic [31:0] wake_mask_reg;
	logic [N_IO-1:0] io_snap_reg;
	logic sns_reg;
	logic wb_req;
	logic wb_wr;
	logic mode_wr;
	logic wake_any;
	logic shdn_wake;
	logic held_rel;
	logic soft_rst;
	logic cfg_clr;
	logic [31:0] rdata;

	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	// Writes land in the request cycle; the ack follows one cycle later
	assign wb_req = cyc_i && stb_i && !ack_o;
	assign wb_wr = wb_req && we_i;
	assign mode_wr = wb_wr && adr_i == `PMC_OFS_MODE && sel_i[0];

	assign wake_any = ext_wake_i || rtc_evt_i || sensor_evt_i; // [RULE5]
	assign shdn_wake = |((io_in_i ^ io_snap_reg) & wake_mask_reg[N_IO-1:0]); // [RULE9]
	assign held_rel = state_reg == pmc_pkg::st_held && !reset_pin_i; // [RULE22]
	assign soft_rst = held_rel || (state_reg == pmc_pkg::st_shutdown && shdn_wake
		&& !reset_pin_i); // [RULE9]
	// Shutdown and held lose all ordinary register state
	assign cfg_clr = rst_i || soft_rst; // [RULE11] [RULE12]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= wb_req;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (adr_i)
			`PMC_OFS_MODE: rdata[2:0] = state_reg;
			`PMC_OFS_CLK: rdata[4:0] = clk_cfg_reg;
			`PMC_OFS_STAT: begin
				rdata[2:0] = state_reg;
				rdata[`PMC_ST_RADIO] = pwr_o.radio_en;
				rdata[`PMC_ST_HF] = clk_o.hf_on;
				rdata[`PMC_ST_LF] = clk_o.lf_on;
			end
			`PMC_OFS_CAUSE: rdata[2:0] = cause_reg; // [RULE10]
			`PMC_OFS_WAKE: rdata = wake_mask_reg;
			`PMC_OFS_SNS: rdata[0] = sns_reg;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (wb_req && !we_i) begin
			dat_o <= rdata;
		end
	end

	// -----------------------------------------------------------------
	// Configuration registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (cfg_clr) begin
			clk_cfg_reg <= `PMC_CLK_RST;
		end else if (wb_wr && adr_i == `PMC_OFS_CLK && sel_i[0]) begin
			clk_cfg_reg <= dat_i[4:0]; // [RULE4] [RULE17]
		end
	end

	always_ff @(posedge clk_i) begin
		if (cfg_clr) begin
			sns_reg <= `PMC_SNS_RST;
		end else if (wb_wr && adr_i == `PMC_OFS_SNS && sel_i[0]) begin
			sns_reg <= dat_i[`PMC_SNS_CPU]; // [RULE21]
		end
	end

	// Wake mask belongs to the latched pad state, so shutdown keeps it
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_wake_lane
			always_ff @(posedge clk_i) begin
				if (rst_i || held_rel) begin
					wake_mask_reg[8*gb +: 8] <= 8'h00;
				end else if (wb_wr && adr_i == `PMC_OFS_WAKE && sel_i[gb]) begin
					wake_mask_reg[8*gb +: 8] <= dat_i[8*gb +: 8]; // [RULE11]
				end
			end
		end
	endgenerate

	// Pad snapshot taken on the way into shutdown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_snap_reg <= '0;
		end else if (state_reg != pmc_pkg::st_shutdown) begin
			io_snap_reg <= io_in_i; // [RULE8]
		end
	end

	// Latest cause replaces the old one; an event beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_reg <= `PMC_CAUSE_RST; // [RULE10]
		end else if (held_rel) begin
			cause_reg <= 3'h1 << `PMC_CAUSE_PIN; // [RULE10] [RULE13]
		end else if (soft_rst) begin
			cause_reg <= 3'h1 << `PMC_CAUSE_SHDN; // [RULE9] [RULE10]
		end else if (wb_wr && adr_i == `PMC_OFS_CAUSE && sel_i[0]) begin
			cause_reg <= cause_reg & ~dat_i[2:0];
		end
	end

	// -----------------------------------------------------------------
	// Mode sequencer
	// -----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (reset_pin_i) begin
			state_next = pmc_pkg::st_held; // [RULE13]
		end else begin
			unique case (state_reg)
				pmc_pkg::st_active: begin
					if (mode_wr) begin
						if (dat_i[1:0] == `PMC_REQ_IDLE) begin
							state_next = pmc_pkg::st_idle; // [RULE22]
						end else if (dat_i[1:0] == `PMC_REQ_STBY) begin
							state_next = pmc_pkg::st_sb_enter;
						end else if (dat_i[1:0] == `PMC_REQ_SHDN) begin
							state_next = pmc_pkg::st_shutdown;
						end
					end
				end
				pmc_pkg::st_idle: begin
					if (irq_i) begin
						state_next = pmc_pkg::st_active; // [RULE2]
					end
				end
				pmc_pkg::st_sb_enter: begin
					if (lf_tick_i) begin
						state_next = pmc_pkg::st_standby; // [RULE19]
					end
				end
				pmc_pkg::st_standby: begin
					if (wake_any) begin
						state_next = pmc_pkg::st_sb_exit; // [RULE5]
					end
				end
				pmc_pkg::st_sb_exit: begin
					if (lf_tick_i) begin
						state_next = pmc_pkg::st_active; // [RULE19]
					end
				end
				pmc_pkg::st_shutdown: begin
					if (shdn_wake) begin
						state_next = pmc_pkg::st_active; // [RULE9]
					end
				end
				pmc_pkg::st_held: state_next = pmc_pkg::st_active;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pmc_pkg::st_active;
		end else begin
			state_reg <= state_next;
		end
	end

	// -----------------------------------------------------------------
	// Event pulses
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rtimer_sync_o <= 1'b0;
			cpu_resume_o <= 1'b0;
		end else begin
			rtimer_sync_o <= lf_tick_i && !reset_pin_i
				&& (state_reg == pmc_pkg::st_sb_enter
				|| state_reg == pmc_pkg::st_sb_exit); // [RULE19]
			cpu_resume_o <= state_reg == pmc_pkg::st_sb_exit
				&& state_next == pmc_pkg::st_active; // [RULE6]
		end
	end

	// -----------------------------------------------------------------
	// Domain and clock controls
	// -----------------------------------------------------------------
	pmc_pkg::pmc_pwr_t pwr_next;
	pmc_pkg::pmc_clk_t clk_next;
	logic run;
	logic sb;
	logic live;

	always_comb begin
		run = state_reg == pmc_pkg::st_active || state_reg == pmc_pkg::st_idle;
		sb = state_reg == pmc_pkg::st_sb_enter || state_reg == pmc_pkg::st_standby
			|| state_reg == pmc_pkg::st_sb_exit;
		live = run || sb;
		pwr_next = '0;
		pwr_next.cpu_clk = state_reg == pmc_pkg::st_active; // [RULE1] [RULE3]
		pwr_next.mem_clk = state_reg == pmc_pkg::st_active; // [RULE1]
		pwr_next.periph_clk = run; // [RULE1] [RULE3]
		pwr_next.flash_pwr = run; // [RULE3]
		pwr_next.sram_pwr = live; // [RULE12]
		pwr_next.periph_ret = sb; // [RULE6] [RULE12]
		pwr_next.aon_pwr = live; // [RULE5] [RULE8]
		pwr_next.bod_on = live;
		pwr_next.bod_duty = sb;
		pwr_next.wdt_run = run;
		pwr_next.sensor_pwr = live; // [RULE8] [RULE21]
		// Radio needs the crystal; RC accuracy is not enough for it
		pwr_next.radio_en = run && clk_cfg_reg[`PMC_CLK_RADIO]
			&& clk_cfg_reg[`PMC_CLK_HFX]; // [RULE15]
		clk_next = '0;
		// Transit states keep the main clock so the timer resync can run
		clk_next.hf_on = run || state_reg == pmc_pkg::st_sb_enter
			|| state_reg == pmc_pkg::st_sb_exit; // [RULE14]
		clk_next.hf_xtal = clk_cfg_reg[`PMC_CLK_HFX]; // [RULE4] [RULE14]
		clk_next.mf_on = live; // [RULE16]
		clk_next.lf_on = live; // [RULE18]
		clk_next.lf_src = clk_cfg_reg[`PMC_CLK_LF_HI:`PMC_CLK_LF_LO]; // [RULE17]
		clk_next.lf_out = live && clk_cfg_reg[`PMC_CLK_LFOUT]
			&& clk_next.lf_src != `PMC_LF_PIN; // [RULE20]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_o <= '0;
			clk_o <= '0;
		end else begin
			pwr_o <= pwr_next;
			clk_o <= clk_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			io_hold_o <= 1'b0;
			sensor_cpu_own_o <= 1'b0;
		end else begin
			io_hold_o <= state_reg == pmc_pkg::st_standby
				|| state_reg == pmc_pkg::st_shutdown; // [RULE7] [RULE8]
			sensor_cpu_own_o <= sns_reg && live; // [RULE21]
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_idle_irq;
		state_reg == pmc_pkg::st_idle && irq_i && !reset_pin_i;
	endsequence

	sequence s_sb_leave;
		state_reg == pmc_pkg::st_sb_exit && lf_tick_i && !reset_pin_i;
	endsequence

	sequence s_shdn_wake;
		state_reg == pmc_pkg::st_shutdown && shdn_wake && !reset_pin_i;
	endsequence

	AST_IDLE_CLK: assert property (state_reg == pmc_pkg::st_idle |=> // [RULE1]
		!pwr_o.cpu_clk && !pwr_o.mem_clk && pwr_o.periph_clk)
		else $error("idle clock gating wrong");
	AST_IDLE_WAKE: assert property (s_idle_irq |=> state_reg == pmc_pkg::st_active // [RULE2]
		##1 pwr_o.cpu_clk)
		else $error("idle did not wake on interrupt");
	AST_ACTIVE_ON: assert property (state_reg == pmc_pkg::st_active |=> // [RULE3]
		pwr_o.cpu_clk && pwr_o.flash_pwr && pwr_o.sram_pwr)
		else $error("active domains not on");
	AST_HF_SRC: assert property (state_reg == pmc_pkg::st_active |=> // [RULE4]
		clk_o.hf_xtal == $past(clk_cfg_reg[`PMC_CLK_HFX]))
		else $error("main clock source not followed");
	AST_SB_STAY: assert property (state_reg == pmc_pkg::st_standby && !wake_any // [RULE5]
		&& !reset_pin_i |=> state_reg == pmc_pkg::st_standby)
		else $error("standby left without wake event");
	AST_RESUME: assert property (s_sb_leave |=> cpu_resume_o && rtimer_sync_o // [RULE6]
		&& state_reg == pmc_pkg::st_active)
		else $error("standby exit sequence wrong");
	AST_IO_HOLD: assert property (state_reg == pmc_pkg::st_standby |=> io_hold_o) // [RULE7]
		else $error("I/O not held in standby");
	AST_SHDN_OFF: assert property (state_reg == pmc_pkg::st_shutdown |=> // [RULE8]
		!pwr_o.aon_pwr && !pwr_o.sensor_pwr && !clk_o.lf_on && io_hold_o)
		else $error("shutdown left something on");
	AST_SHDN_WAKE: assert property (s_shdn_wake |=> // [RULE9] [RULE10]
		state_reg == pmc_pkg::st_active && cause_reg == 3'h4 && clk_cfg_reg == 5'h00)
		else $error("shutdown wake not a reset");
	AST_PIN_HELD: assert property (reset_pin_i |=> state_reg == pmc_pkg::st_held) // [RULE13]
		else $error("reset pin ignored");
	AST_HF_OFF: assert property (state_reg == pmc_pkg::st_standby |=> // [RULE14] [RULE18]
		!clk_o.hf_on && clk_o.lf_on)
		else $error("standby clock set wrong");
	AST_RADIO: assert property (pwr_o.radio_en |-> clk_o.hf_xtal && clk_o.hf_on) // [RULE15]
		else $error("radio on without crystal");
	AST_LF_OUT: assert property (clk_o.lf_out |-> clk_o.lf_src != 2'h2) // [RULE20]
		else $error("pin clock driven back out");
endmodule : pmc_top

// ### power_mode_clock_manager_tb_top.sv
// Testbench for the power mode and clock manager
`timescale 1ns/1ps
`include "pmc_regs.svh"

module power_mode_clock_manager_tb_top;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc_i = 1'h0;
	logic stb_i = 1'h0;
	logic we_i = 1'h0;
	logic irq_i = 1'h0;
	logic rtc_evt_i = 1'h0;
	logic sensor_evt_i = 1'h0;
	logic ext_wake_i = 1'h0;
	logic reset_pin_i = 1'h0;
	logic flip = 1'h0;
	logic [5:0] adr_i = 6'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o, lf_tick, io_hold_o, cpu_resume_o, rtimer_sync_o, sensor_cpu_own_o;
	logic [30:0] io;
	pmc_pkg::pmc_pwr_t pwr_o;
	pmc_pkg::pmc_clk_t clk_o;
	int failures = 0;
	int comparisons = 0;
	int syncs = 0;
	int s0;

	always #4 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (rtimer_sync_o === 1'h1) begin
			syncs <= syncs + 1;
		end
	end

	pmc_top pmc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .irq_i(irq_i), .rtc_evt_i(rtc_evt_i), .sensor_evt_i(sensor_evt_i),
		.ext_wake_i(ext_wake_i), .reset_pin_i(reset_pin_i), .lf_tick_i(lf_tick),
		.io_in_i(io), .io_hold_o(io_hold_o), .cpu_resume_o(cpu_resume_o),
		.rtimer_sync_o(rtimer_sync_o), .sensor_cpu_own_o(sensor_cpu_own_o),
		.pwr_o(pwr_o), .clk_o(clk_o));

	pmc_far_model pmc_far_model_inst (.clk_i(clk_i), .flip_i(flip), .lf_tick_o(lf_tick),
		.io_o(io));

	task test_done;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; a stuck slave ends the run
	task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'h1) begin
			k++;
			if (k > 50) begin
				failures++;
				$display("FAIL t=%0t no ack", $time);
				test_done();
			end
			@(posedge clk_i);
		end
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
	endtask : wb

	task wr(input logic [5:0] a, input logic [31:0] d);
		wb(1'h1, a, d);
	endtask : wr

	task rdc(input logic [5:0] a, input logic [31:0] exp);
		wb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	task cyc_n(input int c);
		repeat (c) @(posedge clk_i);
	endtask : cyc_n

	// 0 pads held, 1 resume pulse, 2 cpu clock back
	task poll(input int w);
		int k;
		k = 0;
		while (((w == 0) ? io_hold_o : (w == 1) ? cpu_resume_o : pwr_o.cpu_clk) !== 1'h1
			&& k < 200) begin
			@(posedge clk_i);
			k++;
		end
		if (k >= 200) begin
			failures++;
			$display("FAIL t=%0t timeout", $time);
			test_done();
		end
	endtask : poll

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rdc(`PMC_OFS_CAUSE, 32'h1);
		rdc(6'h18, 32'h0);
		chk({pwr_o.cpu_clk, pwr_o.periph_clk, pwr_o.flash_pwr, pwr_o.sram_pwr}, 4'hF);
		chk({clk_o.hf_on, clk_o.mf_on, clk_o.lf_on}, 3'h7);
		wr(`PMC_OFS_CLK, 32'h10);
		rdc(`PMC_OFS_STAT, 32'h30);
		wr(`PMC_OFS_CLK, 32'h11);
		cyc_n(2);
		chk(clk_o.hf_xtal, 1'h1);
		rdc(`PMC_OFS_STAT, 32'h38);
		for (int s = 0; s < 3; s++) begin
			wr(`PMC_OFS_CLK, 32'h19 | (s << 1));
			cyc_n(2);
			chk({clk_o.lf_src, clk_o.lf_out}, {s[1:0], s != 2});
		end
		wr(`PMC_OFS_CLK, 32'h11);
		wr(`PMC_OFS_SNS, 32'h1);
		cyc_n(2);
		chk(sensor_cpu_own_o, 1'h1);
		wr(`PMC_OFS_SNS, 32'h0);
		cyc_n(2);
		chk(sensor_cpu_own_o, 1'h0);
		wr(`PMC_OFS_MODE, 32'h1);
		cyc_n(2);
		chk({pwr_o.cpu_clk, pwr_o.mem_clk, pwr_o.periph_clk}, 3'h1);
		rdc(`PMC_OFS_MODE, 32'h1);
		irq_i <= 1'h1;
		@(posedge clk_i);
		irq_i <= 1'h0;
		cyc_n(3);
		rdc(`PMC_OFS_MODE, 32'h0);
		// Each wake source in turn
		for (int k = 0; k < 3; k++) begin
			s0 = syncs;
			wr(`PMC_OFS_MODE, 32'h2);
			poll(0);
			cyc_n(1);
			chk({pwr_o.cpu_clk, pwr_o.radio_en, clk_o.hf_on, clk_o.lf_on, pwr_o.aon_pwr,
				pwr_o.periph_ret, pwr_o.sram_pwr, pwr_o.bod_on, pwr_o.bod_duty,
				pwr_o.wdt_run}, 10'h07E);
			cyc_n(20);
			chk(io_hold_o, 1'h1);
			{rtc_evt_i, sensor_evt_i, ext_wake_i} <= 3'h1 << k;
			@(posedge clk_i);
			{rtc_evt_i, sensor_evt_i, ext_wake_i} <= 3'h0;
			poll(1);
			cyc_n(1);
			chk(syncs - s0, 32'h2);
			rdc(`PMC_OFS_CLK, 32'h11);
		end
		wr(`PMC_OFS_WAKE, 32'h1);
		wr(`PMC_OFS_MODE, 32'h3);
		cyc_n(3);
		chk({io_hold_o, pwr_o.aon_pwr, pwr_o.sensor_pwr, clk_o.lf_on, clk_o.mf_on,
			pwr_o.flash_pwr}, 6'h20);
		flip <= 1'h1;
		@(posedge clk_i);
		flip <= 1'h0;
		poll(2);
		rdc(`PMC_OFS_CAUSE, 32'h4);
		rdc(`PMC_OFS_CLK, 32'h0);
		rdc(`PMC_OFS_WAKE, 32'h1);
		wr(`PMC_OFS_CAUSE, 32'h7);
		rdc(`PMC_OFS_CAUSE, 32'h0);
		reset_pin_i <= 1'h1;
		cyc_n(4);
		chk({pwr_o.cpu_clk, clk_o.hf_on, clk_o.lf_on, clk_o.mf_on}, 4'h0);
		reset_pin_i <= 1'h0;
		poll(2);
		rdc(`PMC_OFS_CAUSE, 32'h2);
		rdc(`PMC_OFS_WAKE, 32'h0);
		// Reset pin from standby as well, not only from active
		wr(`PMC_OFS_CAUSE, 32'h7);
		wr(`PMC_OFS_MODE, 32'h2);
		poll(0);
		reset_pin_i <= 1'h1;
		cyc_n(4);
		rdc(`PMC_OFS_MODE, 32'h6);
		chk(io_hold_o, 1'h0);
		reset_pin_i <= 1'h0;
		poll(2);
		rdc(`PMC_OFS_CAUSE, 32'h2);
		test_done();
	end
endmodule : power_mode_clock_manager_tb_top
